// ===== design/phywst_pkg.sv
// constants, types and helpers for the write-slot timing block
// assumes one clock at memory-clock rate, inputs synchronous to it
// Notes on behaviour
// - slot 0 leaves first as memory command, then slots in ascending order.
// - half/quarter rate: write in slot 0 aligned, other slots unaligned.
// - write latency fixed by calibration and static after calibration done.
// - one latency unit is 1, 2 or 4 memory clocks per rate.
// - reported write latency lies within 0 to 63 interface clocks.
package phywst_pkg;
    localparam int SLOT_MAX = 4;
    localparam int CMD_W = 3;
    localparam int DQ_W = 8;
    localparam int WLAT_W = 6;
    localparam int WLAT_MEAS_W = 7;
    localparam logic [WLAT_MEAS_W-1:0] WLAT_MAX = 7'h3f;
    localparam int HIST_D = 63;
    // command field is {ras_n, cas_n, we_n}
    localparam logic [CMD_W-1:0] CMD_WRITE = 3'h4;
    localparam logic [CMD_W-1:0] CMD_NOP = 3'h7;
    localparam logic CS_IDLE = 1'h1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS = 1000;
    localparam int CAL_CYC = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CNT_W = 8;

    typedef enum logic [2:0] {
        PHYWST_RATE_FULL = 3'h1,
        PHYWST_RATE_HALF = 3'h2,
        PHYWST_RATE_QUARTER = 3'h4
    } phywst_rate_t;

    typedef enum logic [4:0] {
        PHYWST_CAL_IDLE = 5'h01,
        PHYWST_CAL_RUN = 5'h02,
        PHYWST_CAL_SETTLE = 5'h04,
        PHYWST_CAL_DONE = 5'h08,
        PHYWST_CAL_FAIL = 5'h10
    } phywst_cal_t;

    // last slot index used per interface clock
    function automatic logic [1:0] phywst_last_slot(input phywst_rate_t rate);
        case (rate)
            PHYWST_RATE_HALF: phywst_last_slot = 2'h1;
            PHYWST_RATE_QUARTER: phywst_last_slot = 2'h3;
            default: phywst_last_slot = 2'h0;
        endcase
    endfunction

    function automatic logic phywst_is_wr(input logic cs_n, input logic [CMD_W-1:0] cmd);
        phywst_is_wr = !cs_n && (cmd == CMD_WRITE);
    endfunction
endpackage

// ===== design/phywst_top.sv
// write-slot serialiser, calibration latency holder and write-slot checker
// assumes i_clk is the memory clock; slot buses valid while o_if_beat is high
module phywst_top import phywst_pkg::*; (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire phywst_rate_t i_rate,
    input wire logic i_cal_req,
    input wire logic [WLAT_MEAS_W-1:0] i_wlat_meas,
    input wire logic [SLOT_MAX-1:0] i_cs_n_slots,
    input wire logic [SLOT_MAX*CMD_W-1:0] i_cmd_slots,
    input wire logic [SLOT_MAX-1:0] i_dqs_burst_slots,
    input wire logic [SLOT_MAX-1:0] i_wvalid_slots,
    input wire logic [SLOT_MAX*DQ_W-1:0] i_wdata_slots,
    input wire logic [SLOT_MAX-1:0] i_write_mask_slots,
    output logic o_if_beat,
    output logic [WLAT_W-1:0] o_wlat,
    output logic o_cal_success,
    output logic o_cal_fail,
    output logic o_mem_cs_n,
    output logic [CMD_W-1:0] o_mem_cmd,
    output logic o_mem_dqs_burst,
    output logic o_mem_wvalid,
    output logic [DQ_W-1:0] o_mem_wdata,
    output logic o_mem_write_mask,
    output logic o_wr_aligned,
    output logic o_wr_unaligned,
    output logic o_wr_slot_err
);
    logic [1:0] phase_r;
    logic [1:0] last_slot;
    logic [SLOT_MAX-1:0] hold_cs_r;
    logic [SLOT_MAX*CMD_W-1:0] hold_cmd_r;
    logic [SLOT_MAX-1:0] hold_dqs_r;
    logic [SLOT_MAX-1:0] hold_wv_r;
    logic [SLOT_MAX*DQ_W-1:0] hold_wd_r;
    logic [SLOT_MAX-1:0] hold_wm_r;
    logic [SLOT_MAX-1:0] src_cs;
    logic [SLOT_MAX*CMD_W-1:0] src_cmd;
    logic [SLOT_MAX-1:0] src_dqs;
    logic [SLOT_MAX-1:0] src_wv;
    logic [SLOT_MAX*DQ_W-1:0] src_wd;
    logic [SLOT_MAX-1:0] src_wm;
    logic [SLOT_MAX-1:0] used_mask;
    logic [SLOT_MAX-1:0] wr_mask;
    logic [SLOT_MAX-1:0] exp_mask;
    logic [SLOT_MAX-1:0] hist_r [HIST_D];
    phywst_cal_t cal_r;
    logic [CAL_CNT_W-1:0] cal_cnt_r;
    logic cal_end;

    assign last_slot = phywst_last_slot(i_rate);
    assign o_if_beat = (phase_r == 2'h0);

    // interface beat every 1, 2 or 4 memory clocks
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_r <= 2'h0;
        end else if (phase_r >= last_slot) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // bundle taken at the beat, held for the later slots
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_cs_r <= '1;
            hold_cmd_r <= {SLOT_MAX{CMD_NOP}};
            hold_dqs_r <= '0;
            hold_wv_r <= '0;
            hold_wd_r <= '0;
            hold_wm_r <= '0;
        end else if (o_if_beat) begin
            hold_cs_r <= i_cs_n_slots;
            hold_cmd_r <= i_cmd_slots;
            hold_dqs_r <= i_dqs_burst_slots;
            hold_wv_r <= i_wvalid_slots;
            hold_wd_r <= i_wdata_slots;
            hold_wm_r <= i_write_mask_slots;
        end
    end

    assign src_cs = o_if_beat ? i_cs_n_slots : hold_cs_r;
    assign src_cmd = o_if_beat ? i_cmd_slots : hold_cmd_r;
    assign src_dqs = o_if_beat ? i_dqs_burst_slots : hold_dqs_r;
    assign src_wv = o_if_beat ? i_wvalid_slots : hold_wv_r;
    assign src_wd = o_if_beat ? i_wdata_slots : hold_wd_r;
    assign src_wm = o_if_beat ? i_write_mask_slots : hold_wm_r;

    // slot n leaves on the n-th memory clock of the beat
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mem_cs_n <= CS_IDLE;
            o_mem_cmd <= CMD_NOP;
            o_mem_dqs_burst <= 1'h0;
            o_mem_wvalid <= 1'h0;
            o_mem_wdata <= '0;
            o_mem_write_mask <= 1'h0;
        end else begin
            o_mem_cs_n <= src_cs[phase_r];
            o_mem_cmd <= src_cmd[CMD_W*phase_r +: CMD_W];
            o_mem_dqs_burst <= src_dqs[phase_r];
            o_mem_wvalid <= src_wv[phase_r];
            o_mem_wdata <= src_wd[DQ_W*phase_r +: DQ_W];
            o_mem_write_mask <= src_wm[phase_r];
        end
    end

    always_comb begin
        used_mask = '0;
        wr_mask = '0;
        for (int k = 0; k < SLOT_MAX; k++) begin
            used_mask[k] = (k <= int'(last_slot));
            wr_mask[k] = used_mask[k] && phywst_is_wr(i_cs_n_slots[k], i_cmd_slots[CMD_W*k +: CMD_W]);
        end
    end

    // aligned / unaligned classification, half and quarter rate only
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr_aligned <= 1'h0;
            o_wr_unaligned <= 1'h0;
        end else begin
            o_wr_aligned <= o_if_beat && (i_rate != PHYWST_RATE_FULL) && wr_mask[0];
            o_wr_unaligned <= o_if_beat && (i_rate != PHYWST_RATE_FULL) && !wr_mask[0] && (wr_mask[SLOT_MAX-1:1] != '0);
        end
    end

    // calibration: cal request acts as a synchronous restart
    assign cal_end = (cal_r == PHYWST_CAL_RUN) && (cal_cnt_r == CAL_CNT_W'(CAL_CYC - 1));

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cal_r <= PHYWST_CAL_IDLE;
            cal_cnt_r <= '0;
        end else if (i_cal_req) begin
            cal_r <= PHYWST_CAL_IDLE;
            cal_cnt_r <= '0;
        end else begin
            unique case (cal_r)
                PHYWST_CAL_IDLE: cal_r <= PHYWST_CAL_RUN;
                PHYWST_CAL_RUN: begin
                    cal_cnt_r <= cal_cnt_r + CAL_CNT_W'(1);
                    if (cal_end) begin
                        cal_r <= (i_wlat_meas > WLAT_MAX) ? PHYWST_CAL_FAIL : PHYWST_CAL_SETTLE;
                    end
                end
                PHYWST_CAL_SETTLE: cal_r <= PHYWST_CAL_DONE;
                PHYWST_CAL_DONE: cal_r <= PHYWST_CAL_DONE;
                PHYWST_CAL_FAIL: cal_r <= PHYWST_CAL_FAIL;
            endcase
        end
    end

    // latency latched once, a cycle before done rises
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wlat <= '0;
        end else if (cal_end && !i_cal_req && (i_wlat_meas <= WLAT_MAX)) begin
            o_wlat <= i_wlat_meas[WLAT_W-1:0];
        end
    end

    assign o_cal_success = (cal_r == PHYWST_CAL_DONE);
    assign o_cal_fail = (cal_r == PHYWST_CAL_FAIL);

    // write masks of past beats, for the latency check
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int k = 0; k < HIST_D; k++) begin
                hist_r[k] <= '0;
            end
        end else if (o_if_beat) begin
            hist_r[0] <= o_cal_success ? wr_mask : '0;
            for (int k = 1; k < HIST_D; k++) begin
                hist_r[k] <= hist_r[k-1];
            end
        end
    end

    // data must open wlat beats later in the command's own slot
    assign exp_mask = (o_wlat == '0) ? wr_mask : hist_r[o_wlat - WLAT_W'(1)];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr_slot_err <= 1'h0;
        end else if (i_cal_req) begin
            o_wr_slot_err <= 1'h0;
        end else if (o_if_beat && o_cal_success && ((exp_mask & ~i_wvalid_slots) != '0)) begin
            o_wr_slot_err <= 1'h1;
        end
    end

    sequence s_second_slot_cmd;
        ##1 (o_mem_cmd == $past(i_cmd_slots[2*CMD_W-1:CMD_W], 2));
    endsequence

    property p_slot0_first;
        @(posedge i_clk) disable iff (!i_arst_n)
        o_if_beat |=> (o_mem_cmd == $past(i_cmd_slots[CMD_W-1:0])) && (o_mem_cs_n == $past(i_cs_n_slots[0]));
    endproperty
    a_slot0_first: assert property (p_slot0_first) else $error("slot 0 not emitted first");

    property p_slot1_second;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && i_rate != PHYWST_RATE_FULL) |=> s_second_slot_cmd;
    endproperty
    a_slot1_second: assert property (p_slot1_second) else $error("slot 1 not emitted second");

    property p_lane_order_data;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && i_rate == PHYWST_RATE_QUARTER) |=> ##3 (o_mem_wdata == $past(i_wdata_slots[4*DQ_W-1:3*DQ_W], 4));
    endproperty
    a_lane_order_data: assert property (p_lane_order_data) else $error("data lane 3 not last");

    property p_aligned;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && i_rate != PHYWST_RATE_FULL && !i_cs_n_slots[0] && i_cmd_slots[CMD_W-1:0] == CMD_WRITE)
            |=> o_wr_aligned && !o_wr_unaligned;
    endproperty
    a_aligned: assert property (p_aligned) else $error("aligned write not flagged");

    property p_unaligned;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && i_rate == PHYWST_RATE_HALF && i_cs_n_slots[0] && !i_cs_n_slots[1]
            && i_cmd_slots[2*CMD_W-1:CMD_W] == CMD_WRITE) |=> o_wr_unaligned && !o_wr_aligned;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned write not flagged");

    property p_quarter_unit;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && i_rate == PHYWST_RATE_QUARTER) |=> !o_if_beat [*3] ##1 o_if_beat;
    endproperty
    a_quarter_unit: assert property (p_quarter_unit) else $error("quarter beat not 4 clocks");

    property p_half_unit;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && i_rate == PHYWST_RATE_HALF) |=> !o_if_beat ##1 o_if_beat;
    endproperty
    a_half_unit: assert property (p_half_unit) else $error("half beat not 2 clocks");

    property p_wlat_before_done;
        @(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_cal_success) |-> $stable(o_wlat) && $past(cal_r) == PHYWST_CAL_SETTLE;
    endproperty
    a_wlat_before_done: assert property (p_wlat_before_done) else $error("latency moved at done");

    property p_wlat_static;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_cal_success && $past(o_cal_success)) |-> $stable(o_wlat);
    endproperty
    a_wlat_static: assert property (p_wlat_static) else $error("latency changed after done");

    property p_wlat_range;
        @(posedge i_clk) disable iff (!i_arst_n)
        (cal_end && !i_cal_req && i_wlat_meas > WLAT_MAX) |=> o_cal_fail && !o_cal_success ##1 o_cal_fail;
    endproperty
    a_wlat_range: assert property (p_wlat_range) else $error("out of range latency accepted");

    property p_slot_err;
        @(posedge i_clk) disable iff (!i_arst_n)
        (o_if_beat && o_cal_success && !i_cal_req && ((exp_mask & ~i_wvalid_slots) != '0)) |=> o_wr_slot_err;
    endproperty
    a_slot_err: assert property (p_slot_err) else $error("missing write data not flagged");
endmodule // phywst_top

// ===== verification/phywst_ctrl_model.sv
// controller-side model driving the slot lanes of the write-slot timing block
// assumes beat and write latency from the block; bench requests single writes
module phywst_ctrl_model import phywst_pkg::*; (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_beat,
    input wire logic [WLAT_W-1:0] i_wlat,
    input wire logic i_wr_go,
    input wire logic [1:0] i_wr_slot,
    input wire logic i_drop,
    output logic [SLOT_MAX-1:0] o_cs_n_slots,
    output logic [SLOT_MAX*CMD_W-1:0] o_cmd_slots,
    output logic [SLOT_MAX-1:0] o_dqs_burst_slots,
    output logic [SLOT_MAX-1:0] o_wvalid_slots,
    output logic [SLOT_MAX*DQ_W-1:0] o_wdata_slots,
    output logic [SLOT_MAX-1:0] o_write_mask_slots
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SLOT_MAX-1:0] hist [0:63];
    logic [SLOT_MAX-1:0] due;
    logic go;
    logic drop;
    logic [1:0] slot;
    int n;
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            n = 64;
            foreach (hist[i]) hist[i] = '0;
            o_cs_n_slots = '1;
            o_cmd_slots = '1;
            o_dqs_burst_slots = '0;
            o_wvalid_slots = '0;
            o_wdata_slots = '0;
            o_write_mask_slots = '0;
        end else if (i_beat) begin
            go = i_wr_go;
            slot = i_wr_slot;
            drop = i_drop;
            #1;
            n++;
            hist[n % 64] = go ? 4'h1 << slot : 4'h0;
            due = hist[(n - i_wlat) % 64];
            for (int k = 0; k < SLOT_MAX; k++) begin
                o_cs_n_slots[k] = !hist[n % 64][k];
                o_cmd_slots[k*CMD_W +: CMD_W] = hist[n % 64][k] ? CMD_WRITE : CMD_NOP;
                // idle lanes carry a pattern that moves every beat
                o_wdata_slots[k*DQ_W +: DQ_W] = due[k] ? 8'h5a ^ 8'(k) : 8'(n);
            end
            o_wvalid_slots = due & ~{SLOT_MAX{drop}};
            o_dqs_burst_slots = due;
            o_write_mask_slots = due & 4'ha;
        end
    end
endmodule // phywst_ctrl_model

// ===== verification/tb_top.sv
// self-checking bench for the write-slot timing block
// assumes the controller model in phywst_ctrl_model and a 100 MHz clock
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_top import phywst_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, go, drop, cal_req;
    logic [1:0] slot;
    phywst_rate_t rate;
    logic [WLAT_MEAS_W-1:0] meas;
    logic [SLOT_MAX-1:0] cs_n, dqs, wv, wm;
    logic [SLOT_MAX*CMD_W-1:0] cmd;
    logic [SLOT_MAX*DQ_W-1:0] wd;
    logic beat, succ, fail, mcs, mdqs, mwv, mwm, al, ual, err;
    logic [WLAT_W-1:0] wlat;
    logic [CMD_W-1:0] mcmd;
    logic [DQ_W-1:0] mwd;
    int n_errors = 0;
    int n_checks = 0;

    phywst_top phywst_top_inst (.i_clk(clk), .i_arst_n(arst_n), .i_rate(rate), .i_cal_req(cal_req),
        .i_wlat_meas(meas), .i_cs_n_slots(cs_n), .i_cmd_slots(cmd), .i_dqs_burst_slots(dqs),
        .i_wvalid_slots(wv), .i_wdata_slots(wd), .i_write_mask_slots(wm), .o_if_beat(beat),
        .o_wlat(wlat), .o_cal_success(succ), .o_cal_fail(fail), .o_mem_cs_n(mcs), .o_mem_cmd(mcmd),
        .o_mem_dqs_burst(mdqs), .o_mem_wvalid(mwv), .o_mem_wdata(mwd), .o_mem_write_mask(mwm),
        .o_wr_aligned(al), .o_wr_unaligned(ual), .o_wr_slot_err(err));

    phywst_ctrl_model phywst_ctrl_model_inst (.i_clk(clk), .i_arst_n(arst_n), .i_beat(beat), .i_wlat(wlat),
        .i_wr_go(go), .i_wr_slot(slot), .i_drop(drop), .o_cs_n_slots(cs_n), .o_cmd_slots(cmd),
        .o_dqs_burst_slots(dqs), .o_wvalid_slots(wv), .o_wdata_slots(wd), .o_write_mask_slots(wm));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // bounded wait for calibration to settle either way
    task automatic wait_cal();
        int i;
        for (i = 0; i < 300 && succ !== 1'b1 && fail !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 300) begin
            n_errors++;
            wrap_up();
        end
    endtask

    task automatic restart(input phywst_rate_t r, input logic [WLAT_MEAS_W-1:0] m);
        arst_n = 0;
        rate = r;
        meas = m;
        repeat (12) @(posedge clk);
        #1;
        `CHK(mcs, 1'b1)
        arst_n = 1;
        wait_cal();
    endtask

    // returns just after the next edge that captures a bundle
    task automatic beat_edge();
        int i;
        for (i = 0; i < 8 && beat !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 8) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk);
        #1;
    endtask

    // one write in slot s; checks command, data lane after w beats, flags
    task automatic trip(input int ns, input logic [1:0] s, input logic [WLAT_W-1:0] w, input logic dr,
                        input logic al_x, input logic ual_x);
        `CHK(succ, 1'b1)
        `CHK(wlat, w)
        drop = dr;
        slot = s;
        beat_edge();
        go = 1;
        beat_edge();
        go = 0;
        beat_edge();
        `CHK(al, al_x)
        `CHK(ual, ual_x)
        `CHK(mcs, s != 2'h0)
        repeat (s) @(posedge clk);
        #1;
        `CHK(mcs, 1'b0)
        `CHK(mcmd, CMD_WRITE)
        repeat (int'(w) * ns) @(posedge clk);
        #1;
        `CHK(mwv, !dr)
        `CHK(mdqs, 1'b1)
        `CHK(mwd, 8'h5a ^ {6'h0, s})
        `CHK(mwm, s[0])
        repeat (ns + 1) @(posedge clk);
        #1;
        `CHK(err, dr)
        `CHK(wlat, w)
        drop = 0;
    endtask

    task automatic sc_unaligned_quarter();
        restart(PHYWST_RATE_QUARTER, 7'h01);
        trip(4, 2'h2, 6'h01, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic sc_aligned_half();
        restart(PHYWST_RATE_HALF, 7'h00);
        trip(2, 2'h0, 6'h00, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic sc_missing_valid();
        restart(PHYWST_RATE_HALF, 7'h01);
        trip(2, 2'h1, 6'h01, 1'b1, 1'b0, 1'b1);
        // calibration restart clears the error and keeps the latency
        cal_req = 1'h1;
        @(posedge clk);
        #1;
        cal_req = 1'h0;
        `CHK(err, 1'h0)
        `CHK(succ, 1'h0)
        `CHK(wlat, 6'h01)
        wait_cal();
        trip(2, 2'h1, 6'h01, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic sc_full_rate();
        restart(PHYWST_RATE_FULL, 7'h02);
        trip(1, 2'h0, 6'h02, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic sc_max_latency();
        restart(PHYWST_RATE_QUARTER, 7'h3f);
        trip(4, 2'h3, 6'h3f, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic sc_cal_fail();
        restart(PHYWST_RATE_HALF, 7'h40);
        `CHK(fail, 1'b1)
        `CHK(succ, 1'b0)
    endtask

    initial begin
        arst_n = 0;
        go = 0;
        drop = 0;
        cal_req = 1'h0;
        slot = 2'h0;
        rate = PHYWST_RATE_QUARTER;
        meas = 7'h00;
        sc_unaligned_quarter();
        sc_aligned_half();
        sc_missing_valid();
        sc_full_rate();
        sc_max_latency();
        sc_cal_fail();
        wrap_up();
    end
endmodule // tb_top
